// ---- core/sic_regs.svh ----
`ifndef SIC_REGS_SVH
`define SIC_REGS_SVH
// register indices; the byte address is the index times four
`define SIC_IDX_FAMILY      6'h00
`define SIC_IDX_CHIPREV     6'h01
`define SIC_IDX_GCTRL0      6'h02
`define SIC_IDX_EECTL       6'h03
// code values, arbitrary
`define SIC_FAMILY_CODE     8'h5A
`define SIC_PART_CODE       4'h3
`define SIC_REV_CODE        3'h1
// field positions
`define SIC_RUN_BIT         0
`define SIC_NEWBO_BIT       7
`define SIC_PASSFC_BIT      3
`define SIC_LCAGE_BIT       0
// reset values
`define SIC_GCTRL0_RST      8'h44
// timing
`define SIC_FAST_AGE_US     800
`define SIC_NORM_AGE_S      200
`endif

// ---- core/sic_pkg.sv ----
package sic_pkg;
  typedef struct packed {
    logic [7:0] family;
    logic [7:0] chiprev;
    logic [7:0] gctrl0;
  } sic_image_s;
  typedef enum logic [1:0] {
    SIC_RESET = 2'b00,
    SIC_EEWAIT = 2'b01,
    SIC_STOPPED = 2'b10,
    SIC_RUNNING = 2'b11
  } sic_state_e;
endpackage : sic_pkg

// ---- core/sic_top.sv ----
// Function
// - non-auto strap modes start only after software sets the run bit
// - run bit zero in non-auto strap modes keeps the switch stopped
// - both strap pins low: start automatically once the eeprom attempt ends
// - no eeprom found: registers keep strap and built-in defaults
// - eeprom image valid when byte0 matches family and byte1 high nibble part
// - only a valid image overrides defaults; failed check keeps defaults
// - control bit 7 selects new back-off algorithm, resets zero
// - control bit 3 forwards flow-control frames when set, resets zero
// - link-change age bit: link loss triggers fast aging under 800 us
// - after a fast pass aging returns to the normal period
// - any port losing link ages out all learned addresses
`timescale 1ns/10ps
`default_nettype none
`include "sic_regs.svh"
module sic_top #(
  parameter int          CLK_HZ    = 10_000_000,
  // a fast pass spans FAST_CYC+1 cycles, kept just below the limit
  parameter int unsigned FAST_CYC  = (`SIC_FAST_AGE_US * (CLK_HZ / 1_000_000)) - 2,
  parameter int unsigned NORM_CYC  = `SIC_NORM_AGE_S * CLK_HZ,
  parameter int          NPORTS    = 3
) (
  // clock and reset
  input  wire  logic              sys_clk_i,
  input  wire  logic              nrst_i,
  // apb slave
  input  wire  logic              psel_i,
  input  wire  logic              penable_i,
  input  wire  logic              pwrite_i,
  input  wire  logic [7:0]        paddr_i,
  input  wire  logic [31:0]       pwdata_i,
  output logic                    pready_o,
  output logic [31:0]             prdata_o,
  output logic                    pslverr_o,
  // strap pins
  input  wire  logic              power_strap_mode_hi_i,
  input  wire  logic              power_strap_mode_lo_i,
  // eeprom loader result
  input  wire  logic              ee_done_i,
  input  wire  logic              ee_present_i,
  input  wire  sic_pkg::sic_image_s ee_image_i,
  // port link levels
  input  wire  logic [NPORTS-1:0] link_up_i,
  // switch controls
  output logic                    switch_run_o,
  output logic                    new_backoff_o,
  output logic                    pass_flow_ctrl_o,
  output logic                    age_pulse_o,
  output logic                    flush_all_o,
  output logic                    fast_age_o
);
  import sic_pkg::*;

  sic_state_e        state_q, state_d;
  logic              run_q;
  logic [7:0]        gctrl0_q;
  logic [1:0]        strap_meta_q, strap_q;
  logic [NPORTS-1:0] link_meta_q, link_q, link_old_q;
  logic              fast_q;
  logic [31:0]       age_cnt_q;
  logic              flush_q;
  logic              age_pulse_q;
  logic              img_ok_q;
  logic [7:0]        rdata_q;
  logic [31:0]       fast_len_q;

  // apb decode
  wire        wr_acc   = psel_i & penable_i & pwrite_i;
  wire        hit_fam  = (paddr_i == {`SIC_IDX_FAMILY, 2'b00});
  wire        hit_cr   = (paddr_i == {`SIC_IDX_CHIPREV, 2'b00});
  wire        hit_gc   = (paddr_i == {`SIC_IDX_GCTRL0, 2'b00});
  wire        hit_ee   = (paddr_i == {`SIC_IDX_EECTL, 2'b00});
  wire        mapped   = hit_fam | hit_cr | hit_gc | hit_ee;
  wire [7:0]  cr_val   = {`SIC_PART_CODE, `SIC_REV_CODE, run_q};
  wire [7:0]  rd_byte  = hit_fam ? `SIC_FAMILY_CODE :
                         hit_cr  ? cr_val :
                         hit_gc  ? gctrl0_q :
                         hit_ee  ? {5'h00, img_ok_q, strap_q} : 8'h00;

  // eeprom image check
  wire img_valid = ee_present_i &&
                   (ee_image_i.family == `SIC_FAMILY_CODE) &&
                   (ee_image_i.chiprev[7:4] == `SIC_PART_CODE);
  wire auto_mode = (strap_q == 2'b00);

  // zero wait states: read data is captured in the setup cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o  = {24'h00_0000, rdata_q};

  // read data register, loaded while the setup cycle stands
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      rdata_q <= 8'h00;
    else if (psel_i && !penable_i)
      rdata_q <= rd_byte;
  end

  // strap and link synchronisers
  always_ff @(posedge sys_clk_i)
  begin
    strap_meta_q <= {power_strap_mode_hi_i, power_strap_mode_lo_i};
    strap_q      <= strap_meta_q;
    link_meta_q  <= link_up_i;
    link_q       <= link_meta_q;
  end

  // start sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SIC_RESET:   state_d = SIC_EEWAIT;
      SIC_EEWAIT:  if (!auto_mode) state_d = SIC_STOPPED;
                   else if (ee_done_i) state_d = SIC_RUNNING;
      SIC_STOPPED: if (run_q) state_d = SIC_RUNNING;
      SIC_RUNNING: if (!auto_mode && !run_q) state_d = SIC_STOPPED;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      state_q <= SIC_RESET;
    else
      state_q <= state_d;
  end

  // run bit, software writable
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      run_q <= 1'b0;
    else if (wr_acc && hit_cr)
      run_q <= pwdata_i[`SIC_RUN_BIT];
  end

  // control register; eeprom image loads only when valid
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      gctrl0_q <= `SIC_GCTRL0_RST;
      img_ok_q <= 1'b0;
    end
    else if (state_q == SIC_EEWAIT && auto_mode && ee_done_i)
    begin
      img_ok_q <= img_valid;
      if (img_valid)
        gctrl0_q <= ee_image_i.gctrl0;
    end
    else if (wr_acc && hit_gc)
      gctrl0_q <= pwdata_i[7:0];
  end

  assign switch_run_o     = (state_q == SIC_RUNNING);
  assign new_backoff_o    = gctrl0_q[`SIC_NEWBO_BIT];
  assign pass_flow_ctrl_o = gctrl0_q[`SIC_PASSFC_BIT];

  // link loss detection
  wire link_lost = |(link_old_q & ~link_q);

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      link_old_q <= '0;
    else
      link_old_q <= link_q;
  end

  // aging timer: fast pass on link loss, then normal period
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      fast_q      <= 1'b0;
      age_cnt_q   <= 32'h0000_0000;
      age_pulse_q <= 1'b0;
      flush_q     <= 1'b0;
    end
    else
    begin
      flush_q     <= link_lost;
      age_pulse_q <= 1'b0;
      if (link_lost && gctrl0_q[`SIC_LCAGE_BIT])
      begin
        fast_q    <= 1'b1;
        age_cnt_q <= 32'h0000_0000;
      end
      else if (age_cnt_q >= (fast_q ? FAST_CYC : NORM_CYC))
      begin
        age_pulse_q <= 1'b1;
        fast_q      <= 1'b0;
        age_cnt_q   <= 32'h0000_0000;
      end
      else
        age_cnt_q <= age_cnt_q + 32'h0000_0001;
    end
  end

  assign age_pulse_o = age_pulse_q;
  assign flush_all_o = flush_q;
  assign fast_age_o  = fast_q;

  // checker helper: length of the running fast pass, restarted with it
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i || !fast_q || (link_lost && gctrl0_q[`SIC_LCAGE_BIT]))
      fast_len_q <= 32'h0000_0000;
    else
      fast_len_q <= fast_len_q + 32'h0000_0001;
  end

  // start steps, shared by the properties below
  sequence s_ee_finish;
    state_q == SIC_EEWAIT && auto_mode && ee_done_i;
  endsequence
  sequence s_manual_wait;
    state_q == SIC_EEWAIT && !auto_mode;
  endsequence
  sequence s_run_write;
    wr_acc && hit_cr && pwdata_i[`SIC_RUN_BIT] && state_q == SIC_STOPPED;
  endsequence

  // assertions
  a_stop_norun: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == SIC_STOPPED && !run_q) |=> !switch_run_o)
    else $error("stopped switch ran");
  a_run_start: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == SIC_STOPPED && run_q) |=> switch_run_o)
    else $error("run bit did not start switch");
  a_auto_start: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == SIC_EEWAIT && auto_mode && ee_done_i) |=> switch_run_o)
    else $error("auto start missed");
  a_bad_image: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == SIC_EEWAIT && auto_mode && ee_done_i && !img_valid) |=> $stable(gctrl0_q))
    else $error("invalid image loaded");
  a_good_image: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == SIC_EEWAIT && auto_mode && ee_done_i && img_valid)
      |=> gctrl0_q == $past(ee_image_i.gctrl0))
    else $error("valid image not loaded");
  a_fast_bound: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    fast_q |-> age_cnt_q <= FAST_CYC)
    else $error("fast age overran");
  a_flush_loss: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    link_lost |=> flush_all_o)
    else $error("flush missing on link loss");
  a_code_ro: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (psel_i && penable_i && hit_fam) |-> prdata_o[7:0] == `SIC_FAMILY_CODE)
    else $error("family code changed");
  a_ctrl_bits: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    new_backoff_o == gctrl0_q[7] && pass_flow_ctrl_o == gctrl0_q[3])
    else $error("control outputs wrong");
  a_fast_end: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (age_pulse_o && !$past(link_lost)) |-> !fast_q)
    else $error("fast aging stuck");

  // start and stop checks
  a_manual_stop: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    s_manual_wait |=> !switch_run_o)
    else $error("manual strap mode started alone");
  a_write_start: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    s_run_write |-> ##2 switch_run_o)
    else $error("run bit write did not start switch");
  a_eewait_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == SIC_EEWAIT && auto_mode && !ee_done_i) |=> !switch_run_o)
    else $error("auto start before eeprom attempt ended");
  a_stop_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == SIC_RUNNING && !auto_mode && !run_q) |=> !switch_run_o)
    else $error("cleared run bit did not stop switch");

  // register path checks
  a_run_bit_wr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_acc && hit_cr) |=> run_q == $past(pwdata_i[`SIC_RUN_BIT]))
    else $error("run bit write lost");
  a_gc_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_acc && hit_gc && !(state_q == SIC_EEWAIT && auto_mode && ee_done_i))
      |=> gctrl0_q == $past(pwdata_i[7:0]))
    else $error("control write lost");
  a_rdata_cap: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (psel_i && !penable_i && hit_cr) |=> prdata_o[7:1] == {`SIC_PART_CODE, `SIC_REV_CODE})
    else $error("code fields read wrong");
  a_reset_values: assert property (@(posedge sys_clk_i)
    !nrst_i |=> (gctrl0_q == `SIC_GCTRL0_RST && !run_q && !switch_run_o))
    else $error("reset values wrong");
  a_img_flag: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    s_ee_finish |=> img_ok_q == $past(img_valid))
    else $error("image check result lost");

  // aging checks
  a_flush_cause: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    flush_all_o |-> $past(link_lost))
    else $error("flush without link loss");
  a_fast_len: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    fast_q |-> fast_len_q <= FAST_CYC)
    else $error("fast pass too long");
  a_fast_ends: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ($fell(fast_q) && $past(nrst_i)) |-> age_pulse_o)
    else $error("fast pass ended without age pulse");
endmodule : sic_top
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sic_regs.svh"
module testbench;
  import sic_pkg::*;
  localparam int FASTC = 20;
  localparam int NORMC = 50;
  logic        sys_clk_i, nrst_i, psel_i, penable_i, pwrite_i, hi_i, lo_i;
  logic        ee_done_i, ee_present_i, pready_o, pslverr_o, err;
  logic [7:0]  paddr_i, g;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [2:0]  link_up_i;
  logic        run_o, flush_o, fast_o, age_o, nbo_o, pfc_o;
  wire  [5:0]  outs = {pfc_o, nbo_o, age_o, fast_o, flush_o, run_o};
  sic_image_s  ee_image_i;
  int          n_mismatch, num_checks, c;
  sic_top #(.FAST_CYC(FASTC), .NORM_CYC(NORMC)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .power_strap_mode_hi_i(hi_i), .power_strap_mode_lo_i(lo_i), .ee_done_i(ee_done_i),
    .ee_present_i(ee_present_i), .ee_image_i(ee_image_i), .link_up_i(link_up_i),
    .switch_run_o(run_o), .new_backoff_o(nbo_o), .pass_flow_ctrl_o(pfc_o), .age_pulse_o(age_o),
    .flush_all_o(flush_o), .fast_age_o(fast_o));
  // clock, 100 ns period
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for an output level
  task automatic wait_o(input int s, input logic v, input int lim);
    for (int k = 0; k < lim; k++)
    begin
      @(posedge sys_clk_i);
      if (outs[s] === v)
        return;
    end
    n_mismatch++;
    $display("[FAIL] %0t timeout on output %0d", $time, s);
    print_verdict();
  endtask : wait_o
  // one apb transfer, setup then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge sys_clk_i);
      if (pready_o === 1'b1)
        break;
    end
    if (k == 20)
    begin
      n_mismatch++;
      $display("[FAIL] %0t timeout waiting for pready", $time);
      print_verdict();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rst(input logic h, input logic l);
    nrst_i <= 1'b0;
    hi_i   <= h;
    lo_i   <= l;
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
  endtask : rst
  function automatic logic [7:0] exp_gc(input int cs, input logic [7:0] v);
    return (cs == 1) ? v : `SIC_GCTRL0_RST;
  endfunction : exp_gc
  // main sequence
  initial
  begin
    {psel_i, penable_i, pwrite_i, ee_done_i, ee_present_i} = '0;
    {paddr_i, pwdata_i, ee_image_i} = '0;
    link_up_i = 3'b111;
    nrst_i = 1'b0;
    void'($urandom(32'h383e0233));
    rst(1'b0, 1'b1);
    apb(0, 8'h00, 0);
    chk(rd, {24'h00_0000, `SIC_FAMILY_CODE});
    apb(1, 8'h00, 32'hFFFF_FFFF);
    apb(0, 8'h00, 0);
    chk(rd, {24'h00_0000, `SIC_FAMILY_CODE});
    apb(1, 8'h04, $urandom & 32'hFFFF_FFFE);
    apb(0, 8'h04, 0);
    chk(rd, {24'h00_0000, `SIC_PART_CODE, `SIC_REV_CODE, 1'b0});
    apb(0, 8'h08, 0);
    chk(rd, {24'h00_0000, `SIC_GCTRL0_RST});
    apb(0, 8'h10, 0);
    chk(err, 1'b1);
    chk(outs[0], 1'b0);
    apb(1, 8'h04, 32'h0000_0001);
    wait_o(0, 1'b1, 5);
    apb(1, 8'h04, 32'h0000_0000);
    wait_o(0, 1'b0, 5);
    $display("test 1 done");
    for (c = 0; c < 5; c++)
    begin
      g = {1'($urandom), 3'b100, 1'($urandom), 2'b10, 1'($urandom)};
      apb(1, 8'h08, {24'h00_0000, g});
      apb(0, 8'h08, 0);
      chk(rd, {24'h00_0000, g});
      chk({outs[4], outs[5]}, {g[7], g[3]});
    end
    $display("test 2 done");
    for (c = 1; c >= 0; c--)
    begin
      apb(1, 8'h08, {31'h0000_0022, c[0]});
      link_up_i <= 3'b101;
      wait_o(1, 1'b1, 8);
      if (c == 1)
      begin
        wait_o(2, 1'b1, 6);
        wait_o(2, 1'b0, FASTC + 6);
        wait_o(3, 1'b1, NORMC + 6);
      end
      else
        chk(outs[2], 1'b0);
      link_up_i <= 3'b111;
      repeat (6) @(posedge sys_clk_i);
    end
    $display("test 3 done");
    for (c = 0; c < 4; c++)
    begin
      rst(1'b0, 1'b0);
      g = {1'($urandom), 3'b100, 1'($urandom), 2'b10, 1'($urandom)};
      ee_image_i <= {(c == 3) ? 8'h00 : `SIC_FAMILY_CODE, (c == 2) ? 4'hF : `SIC_PART_CODE,
                     4'($urandom), g};
      ee_present_i <= (c != 0);
      repeat (6) @(posedge sys_clk_i);
      chk(outs[0], 1'b0);
      ee_done_i <= 1'b1;
      @(posedge sys_clk_i);
      ee_done_i <= 1'b0;
      wait_o(0, 1'b1, 5);
      apb(0, 8'h08, 0);
      chk(rd, {24'h00_0000, exp_gc(c, g)});
    end
    $display("test 4 done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
